// ### rtl/pcpb_consts.vh
/*
 Constants for the push-button command block: register offsets, field
 positions, mode encodings, fault codes and class limits.
 Assumes it is included by bare name from design files under rtl/.
*/
`ifndef PCPB_CONSTS_VH
`define PCPB_CONSTS_VH

// ==========================================================
// Register offsets and read-data values
`define PCPB_RESTART_ADDR 8'h18
`define PCPB_POWER_ADDR 8'h19
`define PCPB_CMD_RESET 8'h00
`define PCPB_READ_ZERO 8'h00

// ==========================================================
// Field positions (upper nibble / lower nibble)
`define PCPB_HI_LSB 4
`define PCPB_LO_LSB 0

// ==========================================================
// Operating modes
`define PCPB_MODE_OFF 2'h0
`define PCPB_MODE_MANUAL 2'h1
`define PCPB_MODE_SEMI 2'h2
`define PCPB_MODE_AUTO 2'h3

// ==========================================================
// Fault code for insufficient power
`define PCPB_FAULT_NOPWR 4'h7

// ==========================================================
// Class boundaries
`define PCPB_CLASS_HIGH_MIN 4'h5

`endif

// ### rtl/pcpb_chan.v
/*
 One channel of the push-button command logic: holds deferred restart
 and pending power-on requests and decides when to act on them.
 Assumes one-cycle request pulses from the register decoder and status
 levels from the rest of the controller, all on clk_i.
*/
`include "pcpb_consts.vh"

module pcpb_chan (
   // Clock and reset
   input wire clk_i,
   input wire nrst_i,
   // Mode and channel status
   input wire [1:0] mode_i,
   input wire cooldown_i,
   input wire disconnect_i,
   input wire det_en_i,
   input wire cls_en_i,
   input wire cls_done_i,
   input wire cls_valid_i,
   input wire alloc_ok_i,
   input wire [3:0] class_i,
   input wire four_pair_i,
   input wire single_sig_i,
   input wire partner_on_i,
   input wire is_secondary_i,
   input wire partner_on_req_i,
   // Requests
   input wire det_req_i,
   input wire cls_req_i,
   input wire on_req_i,
   input wire off_req_i,
   // Actions
   output reg det_cycle_o,
   output reg cls_cycle_o,
   output reg det_en_set_o,
   output reg cls_en_set_o,
   output reg single_cycle_o,
   output reg power_on_o,
   output reg power_off_o,
   output reg start_fault_o
);

   reg det_hold_reg;
   reg cls_hold_reg;
   reg on_pend_reg;
   reg cycle_run_reg;
   wire active;
   wire det_go;
   wire cls_go;
   wire single_sig_fail;

   assign active = (mode_i != `PCPB_MODE_OFF);
   // Deferred restart fires once cool-down lifts
   assign det_go = (det_req_i | det_hold_reg) & ~cooldown_i;
   assign cls_go = (cls_req_i | cls_hold_reg) & ~cooldown_i;
   // Lone power-on of a high-class single-signature port cannot be met
   assign single_sig_fail = four_pair_i & single_sig_i & ~partner_on_i & ~partner_on_req_i &
      (class_i >= `PCPB_CLASS_HIGH_MIN);

   // ==========================================================
   // Request holding and action decode
   always @(posedge clk_i) begin
      det_cycle_o <= 1'b0;
      cls_cycle_o <= 1'b0;
      det_en_set_o <= 1'b0;
      cls_en_set_o <= 1'b0;
      single_cycle_o <= 1'b0;
      power_on_o <= 1'b0;
      power_off_o <= 1'b0;
      start_fault_o <= 1'b0;
      if (!nrst_i) begin
         det_hold_reg <= 1'b0;
         cls_hold_reg <= 1'b0;
         on_pend_reg <= 1'b0;
         cycle_run_reg <= 1'b0;
      end else if (off_req_i && active) begin
         // Off wins over a same-write on and drops anything pending
         power_off_o <= 1'b1;
         det_hold_reg <= 1'b0;
         cls_hold_reg <= 1'b0;
         on_pend_reg <= 1'b0;
         cycle_run_reg <= 1'b0;
      end else if (active) begin
         // Restart requests are accepted during cool-down, acted on after
         det_hold_reg <= (det_req_i | det_hold_reg) & cooldown_i;
         cls_hold_reg <= (cls_req_i | cls_hold_reg) & cooldown_i;
         if (mode_i == `PCPB_MODE_MANUAL) begin
            det_cycle_o <= det_go;
            cls_cycle_o <= cls_go;
         end else if (mode_i == `PCPB_MODE_SEMI) begin
            det_en_set_o <= det_go;
            cls_en_set_o <= cls_go;
         end
         if (on_req_i && (cooldown_i || disconnect_i)) begin
            on_pend_reg <= 1'b0;
         end else if (on_req_i) begin
            if (mode_i == `PCPB_MODE_MANUAL) begin
               power_on_o <= 1'b1;
            end else if (is_secondary_i && single_sig_i && partner_on_i) begin
               power_on_o <= 1'b1;
            end else if (four_pair_i && partner_on_i && !single_sig_i) begin
               // Uses only the allocation seen right now; no class is checked
               power_on_o <= alloc_ok_i;
               start_fault_o <= ~alloc_ok_i;
            end else if (mode_i == `PCPB_MODE_AUTO && four_pair_i && !partner_on_req_i) begin
               on_pend_reg <= 1'b0;
            end else begin
               on_pend_reg <= 1'b1;
               // Without cycling enables a single full cycle is started
               if (!(det_en_i && cls_en_i)) begin
                  single_cycle_o <= 1'b1;
                  cycle_run_reg <= 1'b1;
               end
            end
         end else if (on_pend_reg && (cooldown_i || disconnect_i)) begin
            on_pend_reg <= 1'b0;
            cycle_run_reg <= 1'b0;
         end else if (on_pend_reg && cls_done_i) begin
            // Power straight after classification, or give up with no retry
            on_pend_reg <= 1'b0;
            cycle_run_reg <= 1'b0;
            if (single_sig_fail) begin
               start_fault_o <= 1'b1;
            end else if (cls_valid_i && alloc_ok_i) begin
               power_on_o <= 1'b1;
            end
         end
      end else begin
         det_hold_reg <= 1'b0;
         cls_hold_reg <= 1'b0;
         on_pend_reg <= 1'b0;
         cycle_run_reg <= 1'b0;
      end
   end

endmodule // pcpb_chan

// ### rtl/pcpb_top.v
/*
 Push-button command registers for a four-channel power-sourcing quad:
 the restart register and the power-enable register, with per-channel
 action logic.
 Assumes a byte register port from the serial host interface (address,
 data, write and read strobes) on clk_i, and status levels from the rest
 of the controller on the same clock.
*/
`include "pcpb_consts.vh"

// Contract
// - writing 1 triggers that channel's cycle
// - class restarts high nibble, detect low
// - manual mode runs exactly one cycle
// - semi auto sets detect/class enable bit
// - restart register always reads zero
// - restart during cool-down deferred until end
// - power commands act except in off
// - power-off high nibble, power-on low nibble
// - off and on together turn off
// - cool-down or disconnect discards power-on
// - semi auto lone power-on powers one channel
// - high-class single signature lone on faults
// - class four or below powers one pair
// - secondary powers at once after primary
// - dual signature uses partner class, allocation; code checks only alloc_ok_i, no class
// - manual mode power-on is immediate
// - invalid result stays off, no retry
// - pending power-on applied after classification
// - auto with enables off runs one cycle
// - power-off disables and clears channel state
module pcpb_top #(
   parameter NCH = 4
) (
   // Clock and reset
   input wire clk_i,
   input wire nrst_i,
   // Register port
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [7:0] reg_rdata_o,
   output reg reg_hit_o,
   // Mode and status
   input wire [1:0] mode_i,
   input wire [NCH-1:0] cooldown_i,
   input wire [NCH-1:0] disconnect_i,
   input wire [NCH-1:0] det_en_i,
   input wire [NCH-1:0] cls_en_i,
   input wire [NCH-1:0] cls_done_i,
   input wire [NCH-1:0] cls_valid_i,
   input wire [NCH-1:0] alloc_ok_i,
   input wire [4*NCH-1:0] class_i,
   input wire [NCH-1:0] four_pair_i,
   input wire [NCH-1:0] single_sig_i,
   input wire [NCH-1:0] chan_on_i,
   // Actions toward the controller
   output wire [NCH-1:0] det_cycle_o,
   output wire [NCH-1:0] cls_cycle_o,
   output wire [NCH-1:0] det_en_set_o,
   output wire [NCH-1:0] cls_en_set_o,
   output wire [NCH-1:0] single_cycle_o,
   output wire [NCH-1:0] power_on_o,
   output wire [NCH-1:0] power_off_o,
   output wire [NCH-1:0] start_fault_o,
   output reg [3:0] fault_code_o
);

   // ==========================================================
   // Command capture
   reg [NCH-1:0] class_restart_req;
   reg [NCH-1:0] detect_restart_req;
   reg [NCH-1:0] chan_off_req;
   reg [NCH-1:0] chan_on_req;
   wire wr_restart;
   wire wr_power;

   assign wr_restart = reg_wr_i && (reg_addr_i == `PCPB_RESTART_ADDR);
   assign wr_power = reg_wr_i && (reg_addr_i == `PCPB_POWER_ADDR);

   // Bits live for one cycle only, so nothing stays latched
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         class_restart_req <= {NCH{1'b0}};
         detect_restart_req <= {NCH{1'b0}};
         chan_off_req <= {NCH{1'b0}};
         chan_on_req <= {NCH{1'b0}};
      end else begin
         class_restart_req <= wr_restart ? reg_wdata_i[`PCPB_HI_LSB +: NCH] : {NCH{1'b0}};
         detect_restart_req <= wr_restart ? reg_wdata_i[`PCPB_LO_LSB +: NCH] : {NCH{1'b0}};
         // Off mode ignores power commands entirely
         chan_off_req <= (wr_power && mode_i != `PCPB_MODE_OFF) ?
            reg_wdata_i[`PCPB_HI_LSB +: NCH] : {NCH{1'b0}};
         chan_on_req <= (wr_power && mode_i != `PCPB_MODE_OFF) ?
            reg_wdata_i[`PCPB_LO_LSB +: NCH] : {NCH{1'b0}};
      end
   end

   // ==========================================================
   // Read path: both registers are write-only and read as zero
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         reg_rdata_o <= `PCPB_CMD_RESET;
         reg_hit_o <= 1'b0;
      end else begin
         reg_rdata_o <= `PCPB_READ_ZERO;
         reg_hit_o <= (reg_rd_i | reg_wr_i) &&
            ((reg_addr_i == `PCPB_RESTART_ADDR) || (reg_addr_i == `PCPB_POWER_ADDR));
      end
   end

   // ==========================================================
   // Fault code: latest insufficient-power fault
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         fault_code_o <= 4'h0;
      end else if (|start_fault_o) begin
         fault_code_o <= `PCPB_FAULT_NOPWR;
      end
   end

   // ==========================================================
   // Per-channel action logic; 4-pair partners are channel pairs 0/1, 2/3
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : g_chan
         pcpb_chan u_chan (
            .clk_i(clk_i),
            .nrst_i(nrst_i),
            .mode_i(mode_i),
            .cooldown_i(cooldown_i[g]),
            .disconnect_i(disconnect_i[g]),
            .det_en_i(det_en_i[g]),
            .cls_en_i(cls_en_i[g]),
            .cls_done_i(cls_done_i[g]),
            .cls_valid_i(cls_valid_i[g]),
            .alloc_ok_i(alloc_ok_i[g]),
            .class_i(class_i[4*g +: 4]),
            .four_pair_i(four_pair_i[g]),
            .single_sig_i(single_sig_i[g]),
            .partner_on_i(chan_on_i[g ^ 1]),
            .is_secondary_i((g % 2) == 1),
            .partner_on_req_i(chan_on_req[g ^ 1]),
            .det_req_i(detect_restart_req[g]),
            .cls_req_i(class_restart_req[g]),
            .on_req_i(chan_on_req[g]),
            .off_req_i(chan_off_req[g]),
            .det_cycle_o(det_cycle_o[g]),
            .cls_cycle_o(cls_cycle_o[g]),
            .det_en_set_o(det_en_set_o[g]),
            .cls_en_set_o(cls_en_set_o[g]),
            .single_cycle_o(single_cycle_o[g]),
            .power_on_o(power_on_o[g]),
            .power_off_o(power_off_o[g]),
            .start_fault_o(start_fault_o[g])
         );
      end
   endgenerate

endmodule // pcpb_top

// ### verification/pcpb_top_properties.sv
/*
 Checker for the push-button command block, bound to pcpb_top.
 Assumes one clock and the synchronous active-low reset.
*/
module pcpb_top_chk #(
   parameter NCH = 4
) (
   // Clock, reset, register port
   input wire clk_i,
   input wire nrst_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire [7:0] reg_rdata_o,
   // Mode and status
   input wire [1:0] mode_i,
   input wire [NCH-1:0] cooldown_i,
   input wire [NCH-1:0] disconnect_i,
   input wire [NCH-1:0] four_pair_i,
   // Actions
   input wire [NCH-1:0] det_cycle_o,
   input wire [NCH-1:0] cls_cycle_o,
   input wire [NCH-1:0] det_en_set_o,
   input wire [NCH-1:0] cls_en_set_o,
   input wire [NCH-1:0] power_on_o,
   input wire [NCH-1:0] power_off_o
);
   // ==========================================================
   // Properties
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // Clean write: mode held and nothing blocking across the pipeline
   sequence wr_s(logic [7:0] a, logic [1:0] m);
      reg_wr_i && reg_addr_i == a && mode_i == m && four_pair_i == 0
      && (cooldown_i | disconnect_i) == 0 ##1 mode_i == m && (cooldown_i | disconnect_i) == 0;
   endsequence
   read_zero_a: assert property (reg_rdata_o == 8'h00)
      else $error("restart register read not zero");
   manual_restart_a: assert property (wr_s(8'h18, 2'h1) |=>
      {cls_cycle_o, det_cycle_o} == $past(reg_wdata_i, 2)) else $error("manual restart wrong");
   semi_restart_a: assert property (wr_s(8'h18, 2'h2) |=>
      {cls_en_set_o, det_en_set_o} == $past(reg_wdata_i, 2)) else $error("semi enable set wrong");
   manual_power_a: assert property (wr_s(8'h19, 2'h1) |=>
      power_off_o == $past(reg_wdata_i[7:4], 2) && power_on_o == ($past(reg_wdata_i[3:0], 2)
      & ~$past(reg_wdata_i[7:4], 2))) else $error("manual power pulses wrong");
   off_mode_a: assert property ((mode_i == 2'h0)[*3] |->
      (power_on_o | power_off_o | det_cycle_o | cls_cycle_o) == 0) else $error("action in off");
   cool_block_a: assert property (
      (power_on_o & $past(cooldown_i | disconnect_i) & $past(cooldown_i | disconnect_i, 2)) == 0)
      else $error("power-on during cool-down");
   pulse_once_a: assert property (power_off_o != 0 && !$past(reg_wr_i) |=>
      power_off_o == 0) else $error("power-off pulse held");
   quiet_reset_a: assert property ($rose(nrst_i) |->
      (power_on_o | power_off_o | det_cycle_o | cls_cycle_o) == 0) else $error("pulse at reset");
endmodule // pcpb_top_chk

bind pcpb_top pcpb_top_chk #(.NCH(NCH)) chk_i (.clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i,
   .reg_wr_i, .reg_rdata_o, .mode_i, .cooldown_i, .disconnect_i, .four_pair_i, .det_cycle_o,
   .cls_cycle_o, .det_en_set_o, .cls_en_set_o, .power_on_o, .power_off_o);

// ### verification/pcpb_host.sv
/*
 Host model: one strobed byte write or read on the register port.
 Assumes the bench sequences transfers one at a time.
*/
module pcpb_host (
   // Clock and read data
   input wire clk_i,
   input wire [7:0] reg_rdata_i,
   // Register port
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_wr_o,
   output logic reg_rd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle port at time zero
   initial begin
      {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = 18'h0;
   end
   // Idle bus shows the inverse, so stale bytes are never mistaken for new
   task automatic xfer(input logic [7:0] a, d, input logic rd, output logic [7:0] q);
      @(posedge clk_i);
      #1;
      reg_addr_o = a;
      reg_wdata_o = d;
      {reg_wr_o, reg_rd_o} = {!rd, rd};
      @(posedge clk_i);
      #1;
      q = reg_rdata_i;
      {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = {~a, ~d, 2'b00};
   endtask
endmodule // pcpb_host

// ### verification/test_pcpb_top.sv
/*
 Self-checking bench for the push-button command block.
 Assumes the host model and checker are compiled alongside.
*/
module test_pcpb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Signals
   logic clk_i = 0, nrst_i = 0, reg_wr_i, reg_rd_i, reg_hit_o;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, q, d;
   logic [1:0] mode_i = 2'h1;
   logic [3:0] cooldown_i = 0, disconnect_i = 0, det_en_i = 0, cls_en_i = 0, cls_done_i = 0;
   logic [3:0] cls_valid_i = 4'hf, alloc_ok_i = 4'hf, four_pair_i = 0, single_sig_i = 0;
   logic [3:0] chan_on_i = 0, det_cycle_o, cls_cycle_o, det_en_set_o, cls_en_set_o;
   logic [3:0] single_cycle_o, power_on_o, power_off_o, start_fault_o, fault_code_o;
   logic [15:0] class_i = 16'h0;
   logic [31:0] acc, outs, s = 32'd68647;
   int n_errors = 0, n_checks = 0;
   assign outs = {single_cycle_o, start_fault_o, cls_en_set_o, det_en_set_o, cls_cycle_o,
      det_cycle_o, power_off_o, power_on_o};
   // Design, host and clock
   pcpb_top #(.NCH(4)) uut (.*);
   pcpb_host host (.clk_i, .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
      .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));
   always #2.5 clk_i = ~clk_i;
   // ==========================================================
   // Helpers
   function automatic logic [31:0] xs;
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   // Reference: expected pulses gathered over one write
   function automatic logic [31:0] ex(input int m, a, dv);
      ex = 0;
      if (a == 24 && m == 1) ex = dv << 8;
      if (a == 24 && m == 2) ex = dv << 16;
      if (a == 25 && m != 0) ex = ((dv >> 4) << 4) | (dv & ~(dv >> 4) & 15);
   endfunction
   task automatic chk(input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Pulses are ORed over a window so latency slack is not a mismatch
   task automatic run(input int n);
      repeat (n) begin
         @(posedge clk_i);
         #1;
         acc = acc | outs;
      end
   endtask
   task automatic go(input logic [1:0] m, input logic [7:0] a, dv);
      mode_i = m;
      acc = 0;
      host.xfer(a, dv, 1'b0, q);
      run(6);
   endtask
   task automatic cdone;
      cls_done_i = 4'h1;
      run(1);
      cls_done_i = 4'h0;
      run(5);
   endtask
   task automatic wrap_up;
      if (n_errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Watchdog: all scenarios need well under 1000 cycles
   initial begin
      #20000;
      n_errors++;
      wrap_up();
   end
   // ==========================================================
   // Scenarios
   initial begin
      int k;
      repeat (3) @(posedge clk_i);
      #1;
      nrst_i = 1;
      chk(outs, 0);
      for (k = 0; k < 3; k++) begin
         host.xfer(8'(24 + k), 8'hff, 1'b1, q);
         chk({reg_hit_o, q}, {k < 2, 8'h00});
      end
      // Random bytes through off, manual and semi auto
      for (k = 0; k < 12; k++) begin
         d = xs();
         if (k % 6 != 5) begin
            go(2'(k % 3), 8'(24 + k / 3 % 2), d);
            chk(acc, ex(k % 3, 24 + k / 3 % 2, d));
         end
      end
      // Cool-down discards power-on and holds a restart
      cooldown_i = 4'h1;
      go(1, 8'h19, 8'h01);
      chk(acc, 0);
      go(1, 8'h18, 8'h01);
      cooldown_i = 4'h0;
      run(6);
      chk(acc, 32'h100);
      // Semi auto cycling: invalid class, no retry, then pending power-on
      {det_en_i, cls_en_i, cls_valid_i} = 12'hff0;
      go(2, 8'h19, 8'h01);
      cdone();
      cls_valid_i = 4'hf;
      cdone();
      chk(acc, 0);
      go(2, 8'h19, 8'h01);
      cdone();
      chk(acc, 32'h1);
      // 4-pair single signature: class 6 faults, class 3 powers one pair
      {four_pair_i, single_sig_i, class_i} = 24'h330066;
      go(2, 8'h19, 8'h01);
      cdone();
      chk(acc, 32'h1000000);
      chk(fault_code_o, 4'h7);
      class_i = 16'h0033;
      go(2, 8'h19, 8'h01);
      cdone();
      chk(acc, 32'h1);
      chan_on_i = 4'h1;
      go(2, 8'h19, 8'h02);
      chk(acc, 32'h2);
      // Dual signature partner power-on, allocation set before the write;
      // without enough allocation the attempt ends in a start fault
      single_sig_i = 4'h0;
      for (k = 0; k < 2; k++) begin
         alloc_ok_i = {2'b11, k[0], 1'b1};
         go(2, 8'h19, 8'h02);
         chk(acc, k ? 32'h2 : 32'h2000000);
      end
      // Auto with cycling off runs one cycle, then powers
      {four_pair_i, chan_on_i, det_en_i, cls_en_i} = 16'h0;
      go(3, 8'h19, 8'h01);
      cdone();
      chk(acc, 32'h10000001);
      // Auto on a 4-pair port with a lone power-on does nothing
      four_pair_i = 4'h3;
      go(3, 8'h19, 8'h01);
      cdone();
      chk(acc, 0);
      // Reset in mid-run drops a restart held by cool-down
      cooldown_i = 4'h1;
      go(1, 8'h18, 8'h01);
      nrst_i = 0;
      run(2);
      nrst_i = 1;
      cooldown_i = 4'h0;
      run(4);
      chk(acc, 0);
      wrap_up();
   end
endmodule // test_pcpb_top
